// >>> rtl/sdi_top.sv
// sdi_top: serial peripheral data buffer, control, control/status
// and interrupt request logic, with master clock generation and shifter.
// assumes: pins and sck come from outside aclk's domain; the
// processor side (mask, wait, halt) runs on aclk.
//
// Functional notes
// - set done flag (bit 7) when a byte finishes; interrupt if enabled.
// - clear done flag only by status access then data read or write.
// - ignore data writes while the done flag is set.
// - set write collision flag (bit 6) on data write during transfer.
// - set overrun (bit 5) when byte completes while done flag set.
// - reading control/status clears the overrun flag.
// - set mode fault (bit 4) when select goes low in master mode.
// - clear mode fault by status access while set, then control write.
// - output disable bit 2 stops driving the serial data output.
// - select mode bit 1 takes slave select from the level bit.
// - select level bit 0 is active low: 0 selected.
// - as master only a data write starts a byte.
// - last cycle copies received byte to read buffer unless done is already set; reads see buffer.
// - data write loads the shift register directly.
// - in wait keep running; enabled events raise the wake request.
// - in halt ignore bus writes and stall the master clock; slave still shifts.
// - several bytes before halt wake-up give an overrun.
// - only end of transfer wakes from halt; all wake from wait.
// - one shared request, gated by enable and global mask.
// - control/status resets to zero.
// - enable bit 7 permits requests from done, overrun or fault flags.
// - mode fault clears peripheral enable and master select.
// - while fault set, refuse setting enable/master outside sequence.
`timescale 1ns/1ns
`default_nettype none
module sdi_top
   import sdi_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        sck_i,
   output logic             sck_o,
   output logic             sck_oe,
   input  wire logic        mosi_i,
   output logic             mosi_o,
   output logic             mosi_oe,
   input  wire logic        miso_i,
   output logic             miso_o,
   output logic             miso_oe,
   input  wire logic        ss_n_i,
   input  wire logic        cpu_irq_mask,
   input  wire logic        cpu_halt,
   output logic             irq_req,
   output logic             wake_from_wait,
   output logic             wake_from_halt
);

   function automatic logic [1:0] reg_sel(input logic [7:0] a);
      case (a)
         SDI_ADR_DATA: reg_sel = SDI_SEL_DATA;
         SDI_ADR_CTRL: reg_sel = SDI_SEL_CTRL;
         SDI_ADR_CSR:  reg_sel = SDI_SEL_CSR;
         default:      reg_sel = SDI_SEL_NONE;
      endcase
   endfunction

   function automatic logic [6:0] half_of(input logic [2:0] r);
      case (r)
         3'h4:    half_of = SDI_HALF_DIV4;
         3'h0:    half_of = SDI_HALF_DIV8;
         3'h1:    half_of = SDI_HALF_DIV16;
         3'h6:    half_of = SDI_HALF_DIV32;
         3'h2:    half_of = SDI_HALF_DIV64;
         3'h3:    half_of = SDI_HALF_DIV128;
         default: half_of = SDI_HALF_DIV8;
      endcase
   endfunction

   // registers
   sdi_ctrl_t   ctrl_q;
   sdi_sw_t     sw_q;
   logic        done_q;
   logic        write_collision_flag_q;
   logic        ovr_q;
   logic        fault_q;
   logic        arm_q;
   logic        farm_q;
   logic [7:0]  rxbuf_q;
   logic [7:0]  sh_q;
   logic        samp_q;
   logic        dout_q;
   logic        busy_q;
   logic        sck_q;
   logic [6:0]  div_q;
   logic [3:0]  cnt_q;
   logic [7:0]  awaddr_q;
   logic [7:0]  wdata_q;
   logic        wlane_q;
   logic [7:0]  araddr_q;
   logic [3:0]  sck_s_q;
   logic [1:0]  mosi_s_q;
   logic [1:0]  miso_s_q;
   logic [1:0]  ss_s_q;

   // bus decode
   wire         wr_go   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
   wire         rd_go   = ~s_axi_arready & ~s_axi_rvalid;
   wire [1:0]   wsel    = reg_sel(awaddr_q);
   wire [1:0]   rsel    = reg_sel(araddr_q);
   wire         wr_ok   = wr_go & wlane_q & ~cpu_halt;
   wire         dat_wr  = wr_ok & (wsel == SDI_SEL_DATA);
   wire         ctl_wr  = wr_ok & (wsel == SDI_SEL_CTRL);
   wire         csr_wr  = wr_ok & (wsel == SDI_SEL_CSR);
   wire         dat_rd  = rd_go & (rsel == SDI_SEL_DATA);
   wire         csr_rd  = rd_go & (rsel == SDI_SEL_CSR);
   wire         dat_acc = dat_wr | dat_rd;
   wire         csr_acc = csr_wr | csr_rd;

   // slave selection source
   wire         sel_lvl = sw_q.soft_select_mode ?
                          sw_q.soft_select_level : ss_s_q[1];
   wire         sel     = ~sel_lvl;
   wire         en      = ctrl_q.peripheral_enable;
   wire         mst     = ctrl_q.master_select;
   wire         fault   = en & mst & sel;

   // shifter edges; the master clock stalls in halt
   // zero is a counted cycle too, so reload one short of the half period
   wire [6:0]   reload  = half_of({ctrl_q.rate2, ctrl_q.rate1,
                                   ctrl_q.rate0}) - 7'h01;
   wire         m_tick  = busy_q & mst & (div_q == 7'h00) & ~cpu_halt;
   wire         s_edge  = en & ~mst & sel & (sck_s_q[2] ^ sck_s_q[1]);
   wire         edge_ev = m_tick | s_edge;
   wire         new_sck = mst ? ~sck_q : sck_s_q[1];
   wire         lead    = new_sck ^ ctrl_q.cpol;
   wire         samp_ev = edge_ev & (lead ^ ctrl_q.cpha);
   wire         din     = mst ? miso_s_q[1] : mosi_s_q[1];
   wire [7:0]   sh_in   = {sh_q[6:0], din};
   wire         done_ev = edge_ev & (cnt_q == SDI_EDGE_LAST);
   wire         s_busy  = (cnt_q != 4'h0) | (sel & ~ctrl_q.cpha);
   wire         collide = mst ? busy_q : (~mst & s_busy);
   // a data write is dropped while done is set or a byte is moving
   wire         dat_ld  = dat_wr & ~done_q & ~collide;

   // flags: set always wins over the clearing sequence
   wire done_d  = done_ev | (done_q & ~(arm_q & dat_acc));
   wire write_collision_flag_d  = (dat_wr & collide) |
                  (write_collision_flag_q & ~(arm_q & dat_acc));
   wire ovr_d   = (done_ev & done_q) | (ovr_q & ~csr_rd);
   wire fault_d = fault | (fault_q & ~(farm_q & ctl_wr));
   wire arm_d   = csr_acc | (arm_q & ~dat_acc);
   wire farm_d  = (csr_acc & fault_q) | (farm_q & ~ctl_wr);

   // control write with fault lockout and hardware clearing
   sdi_ctrl_t ctl_wv;
   sdi_ctrl_t ctrl_d;
   wire       lock = fault_q & ~farm_q;
   always_comb
   begin
      ctl_wv = sdi_ctrl_t'(wdata_q);
      if (lock)
      begin
         ctl_wv.peripheral_enable = 1'b0;
         ctl_wv.master_select     = 1'b0;
      end
      ctrl_d = ctl_wr ? ctl_wv : ctrl_q;
      if (fault)
      begin
         ctrl_d.peripheral_enable = 1'b0;
         ctrl_d.master_select     = 1'b0;
      end
   end

   wire [7:0] csr_val = {done_q, write_collision_flag_q, ovr_q, fault_q, 1'b0,
                         sw_q.output_disable, sw_q.soft_select_mode,
                         sw_q.soft_select_level};
   wire [7:0] rd_val  = (rsel == SDI_SEL_DATA) ? rxbuf_q :
                        (rsel == SDI_SEL_CTRL) ? 8'(ctrl_q) :
                        (rsel == SDI_SEL_CSR)  ? csr_val : 8'h00;

   wire evt_any = ctrl_q.irq_en_bit & (done_q | fault_q | ovr_q);

   // input synchronisers; the second stage is looked at, and for sck the third stage as well for edges
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sck_s_q  <= 4'h0;
         mosi_s_q <= 2'h0;
         miso_s_q <= 2'h0;
         ss_s_q   <= 2'h3;
      end
      else
      begin
         sck_s_q  <= {sck_s_q[2:0], sck_i};
         mosi_s_q <= {mosi_s_q[0], mosi_i};
         miso_s_q <= {miso_s_q[0], miso_i};
         ss_s_q   <= {ss_s_q[0], ss_n_i};
      end
   end

   // register file and flags
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_q  <= sdi_ctrl_t'(SDI_CTRL_RST);
         sw_q    <= sdi_sw_t'(SDI_CSR_RST[2:0]);
         done_q  <= SDI_CSR_RST[SDI_CSR_DONE];
         write_collision_flag_q  <= SDI_CSR_RST[SDI_CSR_WRITE_COLLISION_FLAG];
         ovr_q   <= SDI_CSR_RST[SDI_CSR_OVR];
         fault_q <= SDI_CSR_RST[SDI_CSR_FAULT];
         arm_q   <= 1'b0;
         farm_q  <= 1'b0;
         rxbuf_q <= SDI_DATA_RST;
      end
      else
      begin
         ctrl_q  <= ctrl_d;
         done_q  <= done_d;
         write_collision_flag_q  <= write_collision_flag_d;
         ovr_q   <= ovr_d;
         fault_q <= fault_d;
         arm_q   <= arm_d;
         farm_q  <= farm_d;
         if (csr_wr)
            sw_q <= sdi_sw_t'(wdata_q[2:0]);
         if (done_ev & ~done_q)
            rxbuf_q <= samp_ev ? sh_in : sh_q;
      end
   end

   // shifter and master clock generator
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sh_q   <= SDI_DATA_RST;
         samp_q <= 1'b0;
         dout_q <= 1'b0;
         busy_q <= 1'b0;
         sck_q  <= 1'b0;
         div_q  <= 7'h00;
         cnt_q  <= 4'h0;
      end
      else
      begin
         if (dat_ld)
            sh_q <= wdata_q;
         else if (samp_ev)
            sh_q <= sh_in;
         if (samp_ev)
            samp_q <= din;
         // msb must stand before the first leading edge
         if (dat_ld)
            dout_q <= wdata_q[7];
         else if (edge_ev & ~samp_ev)
            dout_q <= sh_q[7];
         else if (!busy_q && cnt_q == 4'h0)
            dout_q <= sh_q[7];
         if (dat_ld & en & mst)
         begin
            busy_q <= 1'b1;
            div_q  <= reload;
         end
         else if (!mst || !en)
            busy_q <= 1'b0;
         else if (done_ev)
            busy_q <= 1'b0;
         if (m_tick)
            div_q <= reload;
         else if (busy_q && !cpu_halt && div_q != 7'h00)
            div_q <= div_q - 7'h01;
         // idle clock level follows polarity between bytes
         if (m_tick)
            sck_q <= ~sck_q;
         else if (!busy_q)
            sck_q <= ctrl_q.cpol;
         if (edge_ev)
            cnt_q <= cnt_q + 4'h1;
         else if ((!mst && !sel) || !en)
            cnt_q <= 4'h0;
      end
   end

   // AXI4-Lite slave: one write and one read outstanding
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= SDI_RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= SDI_RESP_OKAY;
         s_axi_rdata   <= 32'h0000_0000;
         awaddr_q      <= 8'h00;
         wdata_q       <= 8'h00;
         wlane_q       <= 1'b0;
         araddr_q      <= 8'h00;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awaddr_q      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_q      <= s_axi_wdata[7:0];
            wlane_q      <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wsel == SDI_SEL_NONE) ?
                            SDI_RESP_SLVERR : SDI_RESP_OKAY;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
         if (s_axi_arvalid && s_axi_arready)
         begin
            araddr_q      <= s_axi_araddr;
            s_axi_arready <= 1'b0;
         end
         if (rd_go)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_val};
            s_axi_rresp  <= (rsel == SDI_SEL_NONE) ?
                            SDI_RESP_SLVERR : SDI_RESP_OKAY;
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // pins and requests, all registered
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sck_o          <= 1'b0;
         sck_oe         <= 1'b0;
         mosi_o         <= 1'b0;
         mosi_oe        <= 1'b0;
         miso_o         <= 1'b0;
         miso_oe        <= 1'b0;
         irq_req        <= 1'b0;
         wake_from_wait <= 1'b0;
         wake_from_halt <= 1'b0;
      end
      else
      begin
         sck_o   <= sck_q;
         sck_oe  <= en & mst;
         mosi_o  <= dout_q;
         mosi_oe <= en & mst & ~sw_q.output_disable;
         miso_o  <= dout_q;
         miso_oe <= en & ~mst & sel & ~sw_q.output_disable;
         irq_req <= evt_any & ~cpu_irq_mask;
         wake_from_wait <= evt_any;
         wake_from_halt <= ctrl_q.irq_en_bit & done_q;
      end
   end

endmodule
`default_nettype wire

// >>> rtl/sdi_pkg.sv
// sdi_pkg: register map, field layout and timing constants for the
// serial peripheral status/data/interrupt block.
// assumes: aclk at 100 MHz, registers reached over AXI4-Lite.
package sdi_pkg;

   // printed offsets are register indexes; byte address is index * 4
   localparam logic [7:0] SDI_IDX_DATA = 8'h21;
   localparam logic [7:0] SDI_IDX_CTRL = 8'h22;
   localparam logic [7:0] SDI_IDX_CSR  = 8'h23;
   localparam logic [7:0] SDI_ADR_DATA = {SDI_IDX_DATA[5:0], 2'b00};
   localparam logic [7:0] SDI_ADR_CTRL = {SDI_IDX_CTRL[5:0], 2'b00};
   localparam logic [7:0] SDI_ADR_CSR  = {SDI_IDX_CSR[5:0], 2'b00};

   // register select codes
   localparam logic [1:0] SDI_SEL_NONE = 2'h0;
   localparam logic [1:0] SDI_SEL_DATA = 2'h1;
   localparam logic [1:0] SDI_SEL_CTRL = 2'h2;
   localparam logic [1:0] SDI_SEL_CSR  = 2'h3;

   // control/status bit positions
   localparam int SDI_CSR_DONE  = 7;
   localparam int SDI_CSR_WRITE_COLLISION_FLAG  = 6;
   localparam int SDI_CSR_OVR   = 5;
   localparam int SDI_CSR_FAULT = 4;
   localparam int SDI_CSR_RSVD  = 3;
   localparam int SDI_CSR_ODIS  = 2;
   localparam int SDI_CSR_SMODE = 1;
   localparam int SDI_CSR_SLVL  = 0;

   localparam logic [7:0] SDI_CTRL_RST = 8'h00;
   localparam logic [7:0] SDI_CSR_RST  = 8'h00;
   localparam logic [7:0] SDI_DATA_RST = 8'h00;

   // half serial clock period in aclk cycles, per rate setting
   localparam logic [6:0] SDI_HALF_DIV4   = 7'h02;
   localparam logic [6:0] SDI_HALF_DIV8   = 7'h04;
   localparam logic [6:0] SDI_HALF_DIV16  = 7'h08;
   localparam logic [6:0] SDI_HALF_DIV32  = 7'h10;
   localparam logic [6:0] SDI_HALF_DIV64  = 7'h20;
   localparam logic [6:0] SDI_HALF_DIV128 = 7'h40;

   // sixteen clock edges per byte
   localparam logic [3:0] SDI_EDGE_LAST = 4'hf;

   localparam logic [1:0] SDI_RESP_OKAY   = 2'h0;
   localparam logic [1:0] SDI_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic irq_en_bit;
      logic peripheral_enable;
      logic rate2;
      logic master_select;
      logic cpol;
      logic cpha;
      logic rate1;
      logic rate0;
   } sdi_ctrl_t;

   typedef struct packed {
      logic output_disable;
      logic soft_select_mode;
      logic soft_select_level;
   } sdi_sw_t;

endpackage

// >>> tb/sdi_monitor.sv
// sdi_monitor: port-level assertions for sdi_top, bus and request side.
// assumes: bound into sdi_top, everything on aclk.
`timescale 1ns/1ns
`default_nettype none
module sdi_monitor
   import sdi_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        sck_oe,
   input wire logic        mosi_oe,
   input wire logic        miso_oe,
   input wire logic        cpu_irq_mask,
   input wire logic        irq_req,
   input wire logic        wake_from_wait,
   input wire logic        wake_from_halt
);
   logic [7:0] rd_addr_q;
   logic [7:0] rd_addr_d;
   logic       mapped;
   // address of the read in flight, to judge its answer
   assign rd_addr_d = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr
                                                      : rd_addr_q;
   assign mapped = rd_addr_q inside {SDI_ADR_DATA, SDI_ADR_CTRL, SDI_ADR_CSR};
   always_ff @(posedge aclk)
   begin
      rd_addr_q <= rd_addr_d;
   end
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_wr_lat;
      s_wr_take |-> ##2 s_axi_bvalid;
   endproperty
   property p_rd_lat;
      s_rd_take |-> ##2 s_axi_rvalid;
   endproperty
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   property p_rdata_hi;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
   endproperty
   property p_unmapped;
      s_axi_rvalid && !mapped |-> s_axi_rresp == SDI_RESP_SLVERR
                                  && s_axi_rdata == 32'h0;
   endproperty
   property p_out_dis;
      mosi_oe |-> sck_oe && !miso_oe;
   endproperty
   property p_halt_wake;
      wake_from_halt |-> wake_from_wait;
   endproperty
   property p_mask;
      cpu_irq_mask |=> !irq_req;
   endproperty
   property p_irq_src;
      irq_req |-> wake_from_wait;
   endproperty
   a_wr_lat: assert property (p_wr_lat)
      else $error("write answer late");
   a_rd_lat: assert property (p_rd_lat)
      else $error("read answer late");
   a_ar_block: assert property (p_ar_block)
      else $error("read address open during answer");
   a_rdata_hi: assert property (p_rdata_hi)
      else $error("upper read lanes not zero");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not refused");
   a_out_dis: assert property (p_out_dis)
      else $error("data output enabled outside master");
   a_halt_wake: assert property (p_halt_wake)
      else $error("halt wake without wait wake");
   a_mask: assert property (p_mask)
      else $error("request while masked");
   a_irq_src: assert property (p_irq_src)
      else $error("request without enabled event");
endmodule
bind sdi_top sdi_monitor mon (.*);
`default_nettype wire

// >>> tb/sdi_peer.sv
// sdi_peer: far-side serial device, mode 0 (clock idles low).
// assumes: slave to the block's master clock; master via send().
`timescale 1ns/1ns
`default_nettype none
module sdi_peer
(
   input  wire logic sck_o,
   input  wire logic mosi_o,
   output logic      sck_i,
   output logic      mosi_i,
   output logic      miso_i,
   output logic      ss_n_i
);
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   initial
   begin
      sck_i = 1'b0;
      mosi_i = 1'b0;
      ss_n_i = 1'b1;
      tx_q = 8'h00;
      rx_q = 8'h00;
   end
   assign miso_i = tx_q[7];
   // shift on falling edge so the bit is settled well before sampling
   always @(negedge sck_o) tx_q = {tx_q[6:0], ~tx_q[0]};
   always @(posedge sck_o) rx_q = {rx_q[6:0], mosi_o};
   task automatic load(input logic [7:0] b);
      tx_q = b;
   endtask
   task automatic set_ss(input logic v);
      ss_n_i <= v;
   endtask
   // clock stands still between frames; data line shows the inverse
   task automatic send(input logic [7:0] b);
      ss_n_i <= 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         mosi_i <= b[i];
         #63 sck_i = 1'b1;
         #62 sck_i = 1'b0;
      end
      #63 mosi_i <= ~b[0];
      ss_n_i <= 1'b1;
   endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// tb: self-checking bench for sdi_top over AXI4-Lite and serial pins.
// assumes: sdi_peer on the pins, sdi_monitor bound to the top.
`timescale 1ns/1ns
`default_nettype none
module tb
   import sdi_pkg::*;
;
   logic        aclk, aresetn, cpu_irq_mask, cpu_halt;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, sck_i, sck_o, sck_oe;
   logic        mosi_i, mosi_o, mosi_oe, miso_i, miso_o, miso_oe;
   logic        ss_n_i, irq_req, wake_from_wait, wake_from_halt;
   int          fails = 0;
   int          samples_checked = 0;
   sdi_top DUT (.*);
   sdi_peer peer (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      if (fails == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er = SDI_RESP_OKAY);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge aclk);
         aw_done = aw_done || s_axi_awready;
         w_done = w_done || s_axi_wready;
         s_axi_awvalid <= !aw_done;
         s_axi_wvalid <= !w_done;
      end
      do
         @(posedge aclk);
      while (s_axi_bvalid !== 1'b1);
      chk(32'(s_axi_bresp), 32'(er));
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                     input logic [1:0] er = SDI_RESP_OKAY);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
         @(posedge aclk);
      while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do
         @(posedge aclk);
      while (s_axi_rvalid !== 1'b1);
      chk(s_axi_rdata, {24'h0, exp});
      chk(32'(s_axi_rresp), 32'(er));
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic wait_irq(input logic v);
      int n;
      n = 0;
      while (irq_req !== v && n < 300)
      begin
         @(posedge aclk);
         n++;
      end
      chk(32'(irq_req), 32'(v));
   endtask
   task automatic t_regs();
      rd(SDI_ADR_CTRL, SDI_CTRL_RST);
      rd(SDI_ADR_CSR, SDI_CSR_RST);
      rd(SDI_ADR_DATA, SDI_DATA_RST);
      rd(8'h90, 8'h00, SDI_RESP_SLVERR);
      wr(8'h90, 8'h5a, SDI_RESP_SLVERR);
      cpu_halt <= 1'b1;
      wr(SDI_ADR_CTRL, 8'h0c);
      cpu_halt <= 1'b0;
      rd(SDI_ADR_CTRL, 8'h00);
   endtask
   task automatic t_master();
      peer.load(8'h3c);
      wr(SDI_ADR_CTRL, 8'hd0);
      wr(SDI_ADR_DATA, 8'ha5);
      wr(SDI_ADR_DATA, 8'h11);
      wait_irq(1'b1);
      chk(32'(peer.rx_q), 32'h0000_00a5);
      chk(32'(wake_from_halt), 32'h1);
      cpu_irq_mask <= 1'b1;
      repeat (2) @(posedge aclk);
      chk(32'(irq_req), 32'h0);
      cpu_irq_mask <= 1'b0;
      wr(SDI_ADR_DATA, 8'h77);
      repeat (80) @(posedge aclk);
      chk(32'(peer.rx_q), 32'h0000_00a5);
      rd(SDI_ADR_CSR, 8'hc0);
      rd(SDI_ADR_DATA, 8'h3c);
      rd(SDI_ADR_CSR, 8'h00);
      chk(32'(irq_req), 32'h0);
   endtask
   task automatic t_fault();
      wr(SDI_ADR_CSR, 8'h03);
      peer.set_ss(1'b0);
      wr(SDI_ADR_CTRL, 8'hd0);
      repeat (8) @(posedge aclk);
      chk(32'(sck_oe), 32'h1);
      wr(SDI_ADR_CSR, 8'h02);
      wait_irq(1'b1);
      chk(32'(sck_oe), 32'h0);
      chk(32'(wake_from_halt), 32'h0);
      chk(32'(wake_from_wait), 32'h1);
      peer.set_ss(1'b1);
      rd(SDI_ADR_CTRL, 8'h80);
      wr(SDI_ADR_CTRL, 8'hd0);
      rd(SDI_ADR_CTRL, 8'h80);
      rd(SDI_ADR_CSR, 8'h12);
      wr(SDI_ADR_CSR, 8'h00);
      wr(SDI_ADR_CTRL, 8'hd0);
      rd(SDI_ADR_CTRL, 8'hd0);
      rd(SDI_ADR_CSR, 8'h00);
      wr(SDI_ADR_CSR, 8'h04);
      chk(32'(mosi_oe), 32'h0);
      chk(32'(sck_oe), 32'h1);
      wr(SDI_ADR_CSR, 8'h00);
      chk(32'(mosi_oe), 32'h1);
   endtask
   // second byte lands while halted, before software can react
   task automatic t_slave();
      wr(SDI_ADR_CTRL, 8'hc0);
      wr(SDI_ADR_DATA, 8'h81);
      wr(SDI_ADR_CSR, 8'h02);
      chk(32'({miso_oe, miso_o}), 32'h3);
      wr(SDI_ADR_CSR, 8'h06);
      chk(32'(miso_oe), 32'h0);
      wr(SDI_ADR_CSR, 8'h00);
      cpu_halt <= 1'b1;
      peer.send(8'h5a);
      wait_irq(1'b1);
      peer.send(8'hc3);
      repeat (10) @(posedge aclk);
      chk(32'(wake_from_halt), 32'h1);
      cpu_halt <= 1'b0;
      rd(SDI_ADR_CSR, 8'ha0);
      rd(SDI_ADR_CSR, 8'h80);
      rd(SDI_ADR_DATA, 8'h5a);
      rd(SDI_ADR_CSR, 8'h00);
   endtask
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial
   begin
      #200000;
      fails++;
      wrap_up();
   end
   initial
   begin
      aresetn = 1'b0;
      cpu_irq_mask = 1'b0;
      cpu_halt = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_master();
      t_fault();
      t_slave();
      wrap_up();
   end
endmodule
`default_nettype wire
